//--- tmr_timer.sv
`timescale 1ns/10ps
// What this block does
// R1 - PWM mode decrements each clock, reloads from reload register on underflow
// R2 - Toggle PWM inverts pin each underflow; non-toggle leaves pin alone
// R3 - Reload underflow sets pending; interrupt needs local and global enables
// R4 - With toggling, underflow interrupt coincides with pin transition
// R5 - Event mode counts selected pin edges and reloads on underflow
// R6 - Mode 000 counts rising edges, 001 falling; underflow interrupts
// R7 - Source holds pulses one cycle, edges at most half clock rate
// R8 - Event count reaches zero then underflows on the next event
// R9 - Mode 101 is PWM with toggle, 100 without; clocked counting
// R10 - Capture mode counts clocks; selected edge copies count to capture register
// R11 - Mode 010 captures rising, 011 falling; low bit picks edge
// R12 - Capture mode interrupts on capture or underflow when enabled
// R13 - In capture mode run bit flags underflow, pending flags capture
// R14 - Capture mode counts always; stops after leaving mode and clearing run
// R15 - Capture edge bit changes live without disturbing the count
// R16 - Run bit starts and stops PWM and event counting
// R17 - Software makes the pin an output and presets it before PWM
// R18 - Software alternates reload value each underflow for asymmetric PWM
// R19 - Pending flag stays set until software clear or reset
// R20 - Underflow is the step from 0x0000 to 0xFFFF
// R21 - Reset sets counter to FFFF and reload register to 0000
// R22 - Control byte: mode 7..5, run 4, pending 3, enable 2, 1..0 reserved
// R23 - Pin input synchronised, edges found by comparing successive samples
// R24 - Coincident capture and underflow captures pre-underflow value, sets both flags
module tmr_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_wdata,
  input wire logic count_we,
  input wire logic [15:0] count_wdata,
  input wire logic reload_we,
  input wire logic [15:0] reload_wdata,
  input wire logic global_irq_en,
  input wire logic pin_in,
  input wire logic pin_preset,
  input wire logic pin_preset_we,
  output logic [7:0] ctrl_rdata,
  output logic [15:0] count_rdata,
  output logic [15:0] reload_rdata,
  output logic pin_out,
  output logic irq_req
);
  // ==========================================================
  // State
  logic [2:0] mode_r;
  logic run_r;
  logic pend_r;
  logic irq_en_r;
  logic [15:0] count_r;
  logic [15:0] reload_capture_reg_r;
  logic pin_r;
  tmr_edge_if edges ();

  tmr_edge_det u_edge (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in(pin_in),
    .edges(edges)
  );

  // ==========================================================
  // Mode decode
  logic is_cap;
  logic is_pwm;
  logic is_evt;
  logic sel_edge;
  logic step;
  logic underflow;
  logic capture;
  assign is_cap = (mode_r == tmr_pkg::MODE_CAP_POS) || (mode_r == tmr_pkg::MODE_CAP_NEG);
  // R9 PWM mode decode
  assign is_pwm = (mode_r == tmr_pkg::MODE_PWM_TOG) || (mode_r == tmr_pkg::MODE_PWM_NOTOG);
  assign is_evt = (mode_r == tmr_pkg::MODE_EVT_POS) || (mode_r == tmr_pkg::MODE_EVT_NEG);
  // R6 R11 R15 edge select by low mode bit, read live
  assign sel_edge = mode_r[0] ? edges.fall : edges.rise;
  // R1 R5 R10 R14 R16 counting source
  assign step = is_cap | (is_pwm & run_r) | (is_evt & run_r & sel_edge);
  // R20 underflow detect
  assign underflow = step && (count_r == tmr_pkg::COUNT_ZERO);
  assign capture = is_cap & sel_edge;

  // Control fields
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_r <= tmr_pkg::MODE_RST;
      irq_en_r <= 1'b0;
    end else if (ctrl_we) begin
      mode_r <= ctrl_wdata[tmr_pkg::MODE_HI_BIT:tmr_pkg::MODE_LO_BIT];
      irq_en_r <= ctrl_wdata[tmr_pkg::IRQ_EN_BIT];
    end
  end

  // R13 run bit doubles as underflow flag in capture mode; set wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else if (is_cap && underflow) begin
      run_r <= 1'b1;
    end else if (ctrl_we) begin
      run_r <= ctrl_wdata[tmr_pkg::RUN_BIT];
    end
  end

  // R3 R19 R24 pending flag; hardware set beats software clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else if ((is_cap && capture) || (!is_cap && underflow)) begin
      pend_r <= 1'b1;
    end else if (ctrl_we) begin
      pend_r <= ctrl_wdata[tmr_pkg::PEND_BIT];
    end
  end

  // R1 R5 R8 R21 counter with reload on underflow
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_r <= tmr_pkg::COUNT_RST;
    end else if (count_we) begin
      count_r <= count_wdata;
    end else if (underflow && !is_cap) begin
      count_r <= reload_capture_reg_r;
    end else if (step) begin
      count_r <= count_r - 16'h0001;
    end
  end

  // R10 R24 reload/capture register; capture takes pre-step value
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reload_capture_reg_r <= tmr_pkg::RELOAD_RST;
    end else if (capture) begin
      reload_capture_reg_r <= count_r;
    end else if (reload_we) begin
      reload_capture_reg_r <= reload_wdata;
    end
  end

  // R2 R4 pin toggles with the underflow that raises pending
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_r <= 1'b0;
    end else if (underflow && mode_r == tmr_pkg::MODE_PWM_TOG) begin
      pin_r <= ~pin_r;
    end else if (pin_preset_we) begin
      pin_r <= pin_preset;
    end
  end

  // R12 interrupt on capture or underflow
  tmr_irq_gate u_irq (
    .clock(clock),
    .rst_n(rst_n),
    .pend_a(pend_r),
    .pend_b(is_cap & run_r),
    .irq_en(irq_en_r),
    .global_en(global_irq_en),
    .irq_req(irq_req)
  );

  // R22 readback registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_rdata <= 8'h00;
      count_rdata <= tmr_pkg::COUNT_RST;
      reload_rdata <= tmr_pkg::RELOAD_RST;
      pin_out <= 1'b0;
    end else begin
      ctrl_rdata <= {mode_r, run_r, pend_r, irq_en_r, 2'b00};
      count_rdata <= count_r;
      reload_rdata <= reload_capture_reg_r;
      pin_out <= pin_r;
    end
  end

  // ==========================================================
  // Checks
  // R1 reload on underflow
  a_reload_on_uf: assert property (@(posedge clock) disable iff (!rst_n)
    (underflow && !is_cap && !count_we) |=> count_r == $past(reload_capture_reg_r)) // R1
    else $error("no reload on underflow");
  // R2 toggle
  a_pin_toggle: assert property (@(posedge clock) disable iff (!rst_n)
    (underflow && mode_r == tmr_pkg::MODE_PWM_TOG) |=> pin_r != $past(pin_r)) // R2
    else $error("pin did not toggle");
  // R2 no toggle
  a_pin_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (mode_r == tmr_pkg::MODE_PWM_NOTOG && !pin_preset_we) |=> $stable(pin_r)) // R2
    else $error("pin moved without toggle");
  // R3 pending set
  a_pend_set: assert property (@(posedge clock) disable iff (!rst_n)
    (underflow && !is_cap) |=> pend_r) // R3
    else $error("pending not set");
  // R3 irq gating
  a_irq_gate: assert property (@(posedge clock) disable iff (!rst_n)
    irq_req |-> $past(irq_en_r) && $past(global_irq_en)) // R3
    else $error("irq without enables");
  // R16 stopped
  a_stop_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (!is_cap && !run_r && !count_we) |=> count_r == $past(count_r)) // R16
    else $error("counter moved while stopped");
  // R10 capture
  a_capture_val: assert property (@(posedge clock) disable iff (!rst_n)
    capture |=> reload_capture_reg_r == $past(count_r)) // R10
    else $error("capture value wrong");
  // R13 underflow flag
  a_cap_uf_flag: assert property (@(posedge clock) disable iff (!rst_n)
    (is_cap && underflow) |=> run_r) // R13
    else $error("underflow flag not set");
  // R14 free run
  a_cap_run: assert property (@(posedge clock) disable iff (!rst_n)
    (is_cap && !count_we) |=> count_r == $past(count_r) - 16'h0001) // R14
    else $error("capture mode not counting");
  c_pwm_uf: cover property (@(posedge clock) underflow && is_pwm);
  c_evt_uf: cover property (@(posedge clock) underflow && is_evt);
  c_cap_both: cover property (@(posedge clock) capture && underflow);
endmodule

//--- tmr_pkg.sv
package tmr_pkg;
  // ==========================================================
  // Control byte layout
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_MID_BIT = 6;
  localparam int MODE_LO_BIT = 5;
  localparam int RUN_BIT = 4;
  localparam int PEND_BIT = 3;
  localparam int IRQ_EN_BIT = 2;
  // ==========================================================
  // Mode codes
  localparam logic [2:0] MODE_EVT_POS = 3'h0;
  localparam logic [2:0] MODE_EVT_NEG = 3'h1;
  localparam logic [2:0] MODE_CAP_POS = 3'h2;
  localparam logic [2:0] MODE_CAP_NEG = 3'h3;
  localparam logic [2:0] MODE_PWM_NOTOG = 3'h4;
  localparam logic [2:0] MODE_PWM_TOG = 3'h5;
  // ==========================================================
  // Reset values
  localparam logic [15:0] COUNT_RST = 16'hffff;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam int SYNC_STAGES = 2;
endpackage

//--- tmr_edge_if.sv
`timescale 1ns/10ps
// ==========================================================
// Synchronised pin level and its edges
interface tmr_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

//--- tmr_edge_det.sv
`timescale 1ns/10ps
// ==========================================================
// Two-stage synchroniser and edge detector for the timer pin
module tmr_edge_det (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin_in,
  tmr_edge_if.src edges
);
  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  // R23 sync and compare
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Edges from successive synchronised samples
  assign edges.level = sync2_r;
  assign edges.rise = sync2_r & ~prev_r;
  assign edges.fall = ~sync2_r & prev_r;
endmodule

//--- tmr_irq_gate.sv
`timescale 1ns/10ps
// ==========================================================
// Interrupt request gating, registered
module tmr_irq_gate (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pend_a,
  input wire logic pend_b,
  input wire logic irq_en,
  input wire logic global_en,
  output logic irq_req
);
  // R3 enable gating
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= (pend_a | pend_b) & irq_en & global_en;
    end
  end
endmodule

//--- tmr_pulse_src.sv
`timescale 1ns/10ps
// ==========================================================
// Pulse source driving the timer pin
module tmr_pulse_src (
  input wire logic clock,
  input wire logic go,
  input wire logic [7:0] pulses,
  output logic pin,
  output logic busy
);
  logic [7:0] left_r;
  logic [3:0] ph_r;
  // Idle low, nothing pending
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    left_r = 8'h00;
    ph_r = 4'h0;
  end
  // eight cycles high then four low, well under half rate
  always @(posedge clock) begin
    if (go && !busy) begin
      left_r <= pulses;
      busy <= (pulses != 8'h00);
      ph_r <= 4'h0;
    end else if (busy) begin
      pin <= (ph_r < 4'h8);
      ph_r <= (ph_r == 4'hb) ? 4'h0 : ph_r + 4'h1;
      if (ph_r == 4'hb) begin
        left_r <= left_r - 8'h01;
        busy <= (left_r != 8'h01);
      end
    end
  end
endmodule

//--- tmr_timer_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tmr_timer_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ctrl_we = 1'b0, count_we = 1'b0, reload_we = 1'b0, global_irq_en = 1'b0;
  logic pin_preset = 1'b0, pin_preset_we = 1'b0, go = 1'b0, busy, pin_in, pin_out, irq_req;
  logic [7:0] ctrl_wdata = 8'h00, npul = 8'h00, ctrl_rdata;
  logic [15:0] count_wdata = 16'h0000, reload_wdata = 16'h0000, count_rdata, reload_rdata;
  int mismatches = 0;
  int num_checks = 0;
  tmr_timer tmr_timer_inst (.clock, .rst_n, .ctrl_we, .ctrl_wdata, .count_we, .count_wdata,
    .reload_we, .reload_wdata, .global_irq_en, .pin_in, .pin_preset, .pin_preset_we,
    .ctrl_rdata, .count_rdata, .reload_rdata, .pin_out, .irq_req);
  tmr_pulse_src tmr_pulse_src_inst (.clock, .go, .pulses(npul), .pin(pin_in), .busy);
  // 200 MHz clock
  always #2.5 clock = ~clock;
  // ==========================================================
  // Bus helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wctl(input logic [7:0] v);
    ctrl_wdata = v;
    ctrl_we = 1'b1;
    cyc(1);
    ctrl_we = 1'b0;
  endtask
  task automatic wcnt(input logic [15:0] c, input logic [15:0] r);
    count_wdata = c;
    reload_wdata = r;
    count_we = 1'b1;
    reload_we = 1'b1;
    cyc(1);
    count_we = 1'b0;
    reload_we = 1'b0;
  endtask
  task automatic pstart(input logic [7:0] n);
    npul = n;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
  endtask
  task automatic pfin();
    for (int i = 0; i < 200 && busy; i++) cyc(1);
    cyc(8);
  endtask
  task automatic wpin(input logic lvl, output int n);
    n = 0;
    while (pin_out !== lvl && n < 50) begin
      cyc(1);
      n++;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    `CHK("count", 16'hffff, count_rdata)
    `CHK("reload", 16'h0000, reload_rdata)
    wctl(8'h07);
    cyc(1);
    `CHK("ctrl", 8'h04, ctrl_rdata)
    $display("test reset done");
  endtask
  task automatic t_pwm();
    int n;
    logic [15:0] c;
    logic lv;
    pin_preset = 1'b1;
    pin_preset_we = 1'b1;
    cyc(1);
    pin_preset_we = 1'b0;
    global_irq_en = 1'b1;
    wcnt(16'h0001, 16'h0002);
    wctl(8'hb4);
    wpin(1'b0, n);
    wpin(1'b1, n);
    `CHK("period", 3, n)
    `CHK("pend", 1'b1, ctrl_rdata[3])
    `CHK("irq", 1'b1, irq_req)
    global_irq_en = 1'b0;
    cyc(2);
    `CHK("irq global", 1'b0, irq_req)
    global_irq_en = 1'b1;
    wctl(8'h84);
    wctl(8'h84);
    cyc(2);
    `CHK("cleared", 8'h84, ctrl_rdata)
    `CHK("irq cleared", 1'b0, irq_req)
    c = count_rdata;
    cyc(5);
    `CHK("stopped", c, count_rdata)
    lv = pin_out;
    wctl(8'h94);
    cyc(12);
    `CHK("no toggle", lv, pin_out)
    `CHK("pend notog", 1'b1, ctrl_rdata[3])
    $display("test pwm done");
  endtask
  task automatic t_asym();
    int n;
    // Stop twice so a late underflow cannot leave pending set
    wctl(8'h04);
    wctl(8'h04);
    pin_preset = 1'b1;
    pin_preset_we = 1'b1;
    cyc(1);
    pin_preset_we = 1'b0;
    wcnt(16'h0003, 16'h0005);
    wctl(8'hb4);
    wpin(1'b0, n);
    reload_wdata = 16'h0002;
    reload_we = 1'b1;
    cyc(1);
    reload_we = 1'b0;
    wpin(1'b1, n);
    wpin(1'b0, n);
    `CHK("asym phase", 3, n)
    wctl(8'h04);
    wctl(8'h04);
    $display("test asym pwm done");
  endtask
  task automatic t_evt(input logic [7:0] c);
    wctl(8'h04);
    wcnt(16'h0002, 16'h0002);
    wctl(c);
    pstart(8'h02);
    pfin();
    `CHK("evt two", 16'h0000, count_rdata)
    `CHK("evt pend0", 1'b0, ctrl_rdata[3])
    pstart(8'h01);
    cyc(6);
    `CHK("evt edge", c[5] ? 16'h0000 : 16'h0002, count_rdata)
    pfin();
    `CHK("evt three", 16'h0002, count_rdata)
    `CHK("evt pend", 1'b1, ctrl_rdata[3])
    wctl(c & 8'he7);
    pstart(8'h01);
    pfin();
    `CHK("evt stop", 16'h0002, count_rdata)
    $display("test event %h done", c);
  endtask
  task automatic t_cap();
    logic [15:0] a, b;
    wctl(8'h04);
    wcnt(16'h0060, 16'h0000);
    wctl(8'h44);
    cyc(3);
    `CHK("cap runs", 1'b1, count_rdata < 16'h0060)
    pstart(8'h01);
    pfin();
    a = reload_rdata;
    `CHK("cap pos", 1'b1, a < 16'h0060 && a > 16'h0040)
    `CHK("cap pend", 1'b1, ctrl_rdata[3])
    `CHK("cap irq", 1'b1, irq_req)
    wctl(8'h64);
    `CHK("cap live", 1'b1, count_rdata < a)
    pstart(8'h01);
    pfin();
    b = reload_rdata;
    `CHK("cap neg", 1'b1, b < a - 16'h0008 && b > a - 16'h0030)
    for (int i = 0; i < 200 && ctrl_rdata[4] !== 1'b1; i++) cyc(1);
    `CHK("cap uflow", 1'b1, ctrl_rdata[4])
    `CHK("cap wrap", 1'b1, count_rdata > 16'hff00)
    wctl(8'h04);
    cyc(1);
    a = count_rdata;
    cyc(4);
    `CHK("cap stop", a, count_rdata)
    $display("test capture done");
  endtask
  // ==========================================================
  // Verdict and run control
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog against a hung wait
  initial begin
    #30000;
    mismatches++;
    test_done();
  end
  // Main sequence
  initial begin
    cyc(16);
    rst_n = 1'b1;
    cyc(1);
    t_reset();
    t_pwm();
    t_asym();
    t_evt(8'h14);
    t_evt(8'h34);
    t_cap();
    test_done();
  end
endmodule
